/* File: ebws_bus.sv */
// Purpose: external bus cycles with ready stall, wait clock and ranged strobes
// Assumes: CLOCK is the oscillator, RST synchronous active high
// Notes:   data lane input and ready stall pin pass a three stage synchroniser
`include "ebws_defs.svh"
module ebws_bus #(
  parameter logic [3:0] STROBE_CYCLES = 4'h2
) (
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               REQ_VALID,
  input  wire ebws_pkg::ebws_req_s REQ,
  output logic                    REQ_DONE,
  output logic      [7:0]         REQ_RDATA,
  output logic                    ALE,
  output logic                    RD_N,
  output logic                    WR_N,
  output logic      [7:0]         P0_OUT,
  output logic                    P0_OE_N,
  input  wire logic [7:0]         P0_IN,
  output logic      [7:0]         P2_OUT,
  output logic                    P2_OE_N,
  input  wire logic [7:0]         P2_IN,
  input  wire logic               WAIT_N,
  output logic                    WCLK
);
  import ebws_pkg::*;

  ebws_state_s s_reg;
  ebws_state_s s_next;
  logic [9:0]  idx;
  logic        mapped;
  logic [31:0] rd_word;
  logic [7:0]  din;
  logic        stalled;

  assign idx     = PADDR[11:2];
  assign din     = s_reg.cfg_page ? P2_IN : P0_IN;
  assign stalled = (s_reg.bus == ST_STROBE) && (s_reg.cnt == `EBWS_CNT_ZERO)
                   && s_reg.ctl_stall_en && !s_reg.wait_lvl;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    mapped  = 1'b1;
    unique case (idx)
      `EBWS_IDX_STALL: begin
        rd_word[`EBWS_BIT_STALL_EN] = s_reg.ctl_stall_en;
        rd_word[`EBWS_BIT_CLK_EN]   = s_reg.ctl_clk_en;
      end
      `EBWS_IDX_CONFIG: begin
        rd_word[`EBWS_BIT_RANGE_HI:`EBWS_BIT_RANGE_LO] = s_reg.cfg_range;
        rd_word[`EBWS_BIT_PAGE] = s_reg.cfg_page;
      end
      `EBWS_IDX_STATUS: begin
        rd_word[`EBWS_BIT_BUSY]     = (s_reg.bus != ST_IDLE);
        rd_word[`EBWS_BIT_STALLED]  = stalled;
        rd_word[`EBWS_BIT_WAIT_LVL] = s_reg.wait_lvl;
      end
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    // ready stall pin and data lane synchronisers
    s_next.wait_sync = {s_reg.wait_sync[1:0], WAIT_N};
    if (s_reg.wait_sync[1] == s_reg.wait_sync[2]) begin
      s_next.wait_lvl = s_reg.wait_sync[2];
    end
    s_next.din_sync = {s_reg.din_sync[1:0], din};
    // wait clock, one toggle per oscillator cycle
    s_next.wclk = s_reg.ctl_clk_en ? ~s_reg.wclk : 1'b0;
    // apb slave, one wait state
    s_next.pready = 1'b0;
    if (PSEL && PENABLE && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !mapped;
      s_next.prdata  = PWRITE ? 32'h00000000 : rd_word;
    end
    if (PSEL && PENABLE && s_reg.pready && PWRITE) begin
      if (idx == `EBWS_IDX_STALL) begin
        s_next.ctl_stall_en = PWDATA[`EBWS_BIT_STALL_EN];
        s_next.ctl_clk_en   = PWDATA[`EBWS_BIT_CLK_EN];
      end
      if (idx == `EBWS_IDX_CONFIG) begin
        s_next.cfg_range = PWDATA[`EBWS_BIT_RANGE_HI:`EBWS_BIT_RANGE_LO];
        s_next.cfg_page  = PWDATA[`EBWS_BIT_PAGE];
      end
    end
    // external bus cycle
    unique case (s_reg.bus)
      ST_IDLE: begin
        if (REQ_VALID) begin
          s_next.req     = REQ;
          s_next.hit     = ebws_in_range(s_reg.cfg_range, REQ.addr);
          s_next.bus     = ST_ADDR;
          s_next.ale     = 1'b1;
          s_next.p0_out  = REQ.addr[7:0];
          s_next.p2_out  = REQ.addr[15:8];
          s_next.p0_oe_n = 1'b0;
          s_next.p2_oe_n = 1'b0;
        end
      end
      ST_ADDR: begin
        s_next.ale = 1'b0;
        s_next.cnt = STROBE_CYCLES - 4'h1;
        s_next.bus = ST_STROBE;
        if (s_reg.cfg_page) begin
          s_next.p2_out  = s_reg.req.wdata;
          s_next.p2_oe_n = !s_reg.req.write;
        end else begin
          s_next.p0_out  = s_reg.req.wdata;
          s_next.p0_oe_n = !s_reg.req.write;
        end
        s_next.rd_n = !(s_reg.hit && !s_reg.req.write);
        s_next.wr_n = !(s_reg.hit && s_reg.req.write);
      end
      ST_STROBE: begin
        if (s_reg.cnt != `EBWS_CNT_ZERO) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else if (!(s_reg.ctl_stall_en && !s_reg.wait_lvl)) begin
          s_next.cnt = `EBWS_SETTLE_CYCLES;
          s_next.bus = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (s_reg.cnt != `EBWS_CNT_ZERO) begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end else if (s_reg.din_sync[1] == s_reg.din_sync[2]) begin
          s_next.rdata = (s_reg.hit && !s_reg.req.write) ? s_reg.din_sync[2] : 8'h00;
          s_next.rd_n  = 1'b1;
          s_next.wr_n  = 1'b1;
          s_next.bus   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        s_next.p0_oe_n = 1'b1;
        s_next.p2_oe_n = 1'b1;
        s_next.done    = 1'b1;
        s_next.bus     = ST_IDLE;
      end
      default: begin
        s_next.bus = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_reg              <= '0;
      s_reg.ctl_stall_en <= `EBWS_RST_STALL;
      s_reg.ctl_clk_en   <= `EBWS_RST_STALL;
      s_reg.cfg_range    <= `EBWS_RST_RANGE;
      s_reg.cfg_page     <= `EBWS_RST_PAGE;
      s_reg.bus          <= ST_IDLE;
      s_reg.rd_n         <= 1'b1;
      s_reg.wr_n         <= 1'b1;
      s_reg.p0_oe_n      <= 1'b1;
      s_reg.p2_oe_n      <= 1'b1;
      s_reg.wait_sync    <= 3'h7;
      s_reg.wait_lvl     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA    = s_reg.prdata;
  assign PREADY    = s_reg.pready;
  assign PSLVERR   = s_reg.pslverr;
  assign REQ_DONE  = s_reg.done;
  assign REQ_RDATA = s_reg.rdata;
  assign ALE       = s_reg.ale;
  assign RD_N      = s_reg.rd_n;
  assign WR_N      = s_reg.wr_n;
  assign P0_OUT    = s_reg.p0_out;
  assign P0_OE_N   = s_reg.p0_oe_n;
  assign P2_OUT    = s_reg.p2_out;
  assign P2_OE_N   = s_reg.p2_oe_n;
  assign WCLK      = s_reg.wclk;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_strobe_end;
    (s_reg.bus == ST_STROBE) && (s_reg.cnt == `EBWS_CNT_ZERO);
  endsequence

  property p_stall_hold;
    s_strobe_end ##0 (s_reg.ctl_stall_en && !s_reg.wait_lvl) |=> s_reg.bus == ST_STROBE;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall not held");

  property p_stall_release;
    s_strobe_end ##0 s_reg.wait_lvl |=> s_reg.bus == ST_SETTLE;
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("ready not honoured");

  property p_no_stall;
    s_strobe_end ##0 !s_reg.ctl_stall_en |=> s_reg.bus == ST_SETTLE;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("stall pin not ignored");

  property p_wclk_off;
    !s_reg.ctl_clk_en ##1 !s_reg.ctl_clk_en |-> !WCLK;
  endproperty
  a_wclk_off: assert property (p_wclk_off) else $error("wait clock driven when off");

  property p_wclk_half;
    s_reg.ctl_clk_en [*2] |-> WCLK != $past(WCLK);
  endproperty
  a_wclk_half: assert property (p_wclk_half) else $error("wait clock not half rate");

  property p_hit_decode;
    s_reg.bus == ST_ADDR |-> s_reg.hit == ebws_in_range($past(s_reg.cfg_range), s_reg.req.addr);
  endproperty
  a_hit_decode: assert property (p_hit_decode) else $error("range decode wrong");

  property p_wr_range;
    !WR_N |-> s_reg.hit && s_reg.req.write;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write strobe out of range");

  property p_rd_range;
    !RD_N |-> s_reg.hit && !s_reg.req.write;
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("read strobe out of range");

  property p_page_lanes;
    s_reg.cfg_page && s_reg.bus == ST_STROBE && s_reg.req.write |->
      P0_OUT == s_reg.req.addr[7:0] && P2_OUT == s_reg.req.wdata && !P2_OE_N;
  endproperty
  a_page_lanes: assert property (p_page_lanes) else $error("page mode lanes wrong");

  property p_mux_lanes;
    !s_reg.cfg_page && s_reg.bus == ST_STROBE && s_reg.req.write |->
      P0_OUT == s_reg.req.wdata && P2_OUT == s_reg.req.addr[15:8] && !P0_OE_N;
  endproperty
  a_mux_lanes: assert property (p_mux_lanes) else $error("multiplexed lanes wrong");

  property p_fixed_cycle;
    s_reg.bus == ST_IDLE && REQ_VALID && !s_reg.ctl_stall_en |-> ##[4:40] REQ_DONE;
  endproperty
  a_fixed_cycle: assert property (p_fixed_cycle) else $error("bus cycle overran");

  sequence s_take;
    (s_reg.bus == ST_IDLE) && REQ_VALID;
  endsequence

  sequence s_apb_first;
    PSEL && PENABLE && !PREADY;
  endsequence

  property p_ale_pulse;
    s_take |=> ALE ##1 !ALE;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("address latch not one cycle");

  property p_addr_lanes;
    s_take |=> P0_OUT == $past(REQ.addr[7:0]) && P2_OUT == $past(REQ.addr[15:8]);
  endproperty
  a_addr_lanes: assert property (p_addr_lanes) else $error("address lanes wrong");

  property p_apb_ready;
    s_apb_first |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("register answer not one cycle");

  property p_ctl_write;
    PSEL && PENABLE && PREADY && PWRITE && (idx == `EBWS_IDX_STALL) |=>
      s_reg.ctl_stall_en == $past(PWDATA[`EBWS_BIT_STALL_EN])
      && s_reg.ctl_clk_en == $past(PWDATA[`EBWS_BIT_CLK_EN]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("stall control not written");

  property p_done_idle;
    REQ_DONE |-> RD_N && WR_N && P0_OE_N && P2_OE_N && !ALE;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("bus not released at done");

  property p_miss_zero;
    REQ_DONE && !s_reg.hit |-> REQ_RDATA == 8'h00;
  endproperty
  a_miss_zero: assert property (p_miss_zero) else $error("read data outside range");

endmodule

/* File: ebws_defs.svh */
// Purpose: constants for the external bus wait, wait clock and strobe block
// Assumes: one clock (the oscillator), APB register access
// Notes:   register byte address is four times the register index
//
// Overview of operation
// - the ready stall pin is honoured only once software sets bit 0 of stall_control at A7H.
// - the wait clock pin toggles only once software sets bit 1 of stall_control at A7H.
// - an enabled wait clock is a steady square wave at half the oscillator rate.
// - the write strobe goes low only for addresses inside the strobe range field.
// - page mode puts A7:0 on port 0 and A15:8 plus data on port 2, else port 0 multiplexes.
// - all block timing comes from the oscillator clock.
// - the read strobe goes low only for addresses inside the same strobe range field.
`ifndef EBWS_DEFS_SVH
`define EBWS_DEFS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define EBWS_IDX_STALL      10'h0A7
`define EBWS_IDX_CONFIG     10'h0C0
`define EBWS_IDX_STATUS     10'h0C1

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define EBWS_BIT_STALL_EN   0
`define EBWS_BIT_CLK_EN     1
`define EBWS_BIT_RANGE_LO   0
`define EBWS_BIT_RANGE_HI   1
`define EBWS_BIT_PAGE       2
`define EBWS_BIT_BUSY       0
`define EBWS_BIT_STALLED    1
`define EBWS_BIT_WAIT_LVL   2
`define EBWS_RST_STALL      1'b0
`define EBWS_RST_RANGE      2'h0
`define EBWS_RST_PAGE       1'b0

// ----------------------------------------------------------------
// strobe range codes and timing
// ----------------------------------------------------------------
`define EBWS_RANGE_ALL      2'h0
`define EBWS_RANGE_UPPER    2'h1
`define EBWS_RANGE_LOWER    2'h2
`define EBWS_RANGE_NONE     2'h3
`define EBWS_SETTLE_CYCLES  4'h1
`define EBWS_CNT_ZERO       4'h0

`endif

/* File: ebws_pkg.sv */
// Purpose: types shared by the external bus block
// Assumes: ebws_defs.svh constants
// Notes:   one packed state struct holds every flip-flop
`include "ebws_defs.svh"
package ebws_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_STROBE = 3'b010,
    ST_SETTLE = 3'b011,
    ST_HOLD   = 3'b100
  } ebws_bus_e;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ebws_req_s;

  typedef struct packed {
    logic            ctl_stall_en;
    logic            ctl_clk_en;
    logic [1:0]      cfg_range;
    logic            cfg_page;
    ebws_bus_e       bus;
    logic [3:0]      cnt;
    ebws_req_s       req;
    logic            hit;
    logic [7:0]      rdata;
    logic            done;
    logic            wclk;
    logic            ale;
    logic            rd_n;
    logic            wr_n;
    logic [7:0]      p0_out;
    logic            p0_oe_n;
    logic [7:0]      p2_out;
    logic            p2_oe_n;
    logic [2:0]      wait_sync;
    logic            wait_lvl;
    logic [2:0][7:0] din_sync;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } ebws_state_s;

  // strobe range decode
  function automatic logic ebws_in_range(input logic [1:0] range, input logic [15:0] addr);
    unique case (range)
      `EBWS_RANGE_ALL:   ebws_in_range = 1'b1;
      `EBWS_RANGE_UPPER: ebws_in_range = addr[15];
      `EBWS_RANGE_LOWER: ebws_in_range = ~addr[15];
      `EBWS_RANGE_NONE:  ebws_in_range = 1'b0;
    endcase
  endfunction

endpackage

/* File: ebws_mem_model.sv */
// Purpose: external memory on the multiplexed bus
// Assumes: address taken while ale is high
// Notes:   idle lanes show the inverse of the last byte
module ebws_mem_model (
  input  wire logic       clock,
  input  wire logic       page,
  input  wire logic [3:0] stall_len,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] p0_out,
  input  wire logic       p0_oe_n,
  input  wire logic [7:0] p2_out,
  input  wire logic       p2_oe_n,
  output logic      [7:0] p0_in,
  output logic      [7:0] p2_in,
  output logic            wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // storage, lanes, stall
  // ------
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0]  last   = 8'h00;
  logic [3:0]  wcnt   = 4'h0;
  logic [7:0]  rd_val;
  assign rd_val = rd_n ? ~last : mem[addr_q];
  assign p0_in  = ~p0_oe_n ? p0_out : (page ? ~last : rd_val);
  assign p2_in  = ~p2_oe_n ? p2_out : (page ? rd_val : ~last);
  assign wait_n = (wcnt == 4'h0);
  always @(posedge clock) begin
    if (ale) begin
      addr_q <= {p2_out, p0_out};
      wcnt   <= stall_len;
    end else if (wcnt != 4'h0) begin
      wcnt <= wcnt - 4'h1;
    end
    if (!wr_n) begin
      mem[addr_q] <= page ? p2_out : p0_out;
    end
    if (!rd_n) begin
      last <= rd_val;
    end
  end
endmodule

/* File: ebws_bus_tb.sv */
// Purpose: self-checking bench for the external bus block
// Assumes: memory model on the ports, apb register access
// Notes:   expected results queued, a monitor compares them
`include "ebws_defs.svh"
module ebws_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ebws_pkg::*;
  // ------
  // signals
  // ------
  localparam logic [3:0]  SCY     = 4'h6;
  localparam int          NOM     = 11;
  localparam logic [11:0] A_STALL = {`EBWS_IDX_STALL, 2'b00};
  localparam logic [11:0] A_CFG   = {`EBWS_IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_STAT  = {`EBWS_IDX_STATUS, 2'b00};
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, req_valid = 1'b0, req_done, page = 1'b0;
  ebws_req_s   req = '0;
  logic [7:0]  req_rdata, p0_out, p2_out, p0_in, p2_in;
  logic        ale, rd_n, wr_n, p0_oe_n, p2_oe_n, wait_n, wclk;
  logic [3:0]  stall_len = 4'h0;
  logic [32:0] exp_q [$];
  int          errors = 0, total_checks = 0, seed = 32'h00A8, lat;
  always #2 clock = ~clock;
  ebws_bus #(.STROBE_CYCLES(SCY)) dut_u (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REQ_VALID(req_valid), .REQ(req), .REQ_DONE(req_done), .REQ_RDATA(req_rdata),
    .ALE(ale), .RD_N(rd_n), .WR_N(wr_n), .P0_OUT(p0_out), .P0_OE_N(p0_oe_n),
    .P0_IN(p0_in), .P2_OUT(p2_out), .P2_OE_N(p2_oe_n), .P2_IN(p2_in),
    .WAIT_N(wait_n), .WCLK(wclk));
  ebws_mem_model mem_u (
    .clock(clock), .page(page), .stall_len(stall_len), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out),
    .p2_oe_n(p2_oe_n), .p0_in(p0_in), .p2_in(p2_in), .wait_n(wait_n));
  // ------
  // tasks
  // ------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    n = 0;
    exp_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 30);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic inr);
    logic        good, bad;
    logic [15:0] ale_a;
    good = 1'b0;
    bad = 1'b0;
    ale_a = ~a;
    lat = 0;
    exp_q.push_back({25'h0, exp});
    req_valid <= 1'b1;
    req <= {wr, a, d};
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(posedge clock);
      lat++;
      if (ale === 1'b1) ale_a = {p2_out, p0_out};
      good |= ((wr ? wr_n : rd_n) === 1'b0);
      bad |= ((wr ? rd_n : wr_n) === 1'b0);
    end while (req_done !== 1'b1 && lat < 60);
    if (req_done !== 1'b1) begin
      errors++;
      stop_test();
    end
    check({17'h0, ale_a}, {17'h0, a});
    check({31'h0, good, bad}, {31'h0, inr, 1'b0});
    @(posedge clock);
  endtask
  task automatic wclk_run(input logic on);
    logic prev;
    @(posedge clock);
    prev = wclk;
    repeat (8) begin
      @(posedge clock);
      check({32'h0, wclk}, on ? {32'h0, ~prev} : 33'h0);
      prev = wclk;
    end
  endtask
  // ------
  // monitor
  // ------
  always @(posedge clock) begin
    if (pready === 1'b1 || req_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(33'h0, 33'h1);
      end else if (pready === 1'b1) begin
        check({pslverr, prdata}, exp_q.pop_front());
      end else begin
        check({25'h0, req_rdata}, exp_q.pop_front());
      end
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    int          p, i, r, tmp;
    logic        inr;
    logic [7:0]  dat [2];
    logic [15:0] adr [2];
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, A_STALL, 32'h0, 33'h0);
    apb(1'b0, A_CFG, 32'h0, 33'h0);
    apb(1'b1, A_STAT, 32'h7, 33'h0);
    apb(1'b0, A_STAT, 32'h0, 33'h4);
    apb(1'b1, 12'h004, 32'h1, 33'h100000000);
    apb(1'b0, 12'h004, 32'h0, 33'h100000000);
    $display("test registers done");
    wclk_run(1'b0);
    apb(1'b1, A_STALL, 32'h2, 33'h0);
    apb(1'b0, A_STALL, 32'h0, 33'h2);
    wclk_run(1'b1);
    apb(1'b1, A_STALL, 32'h0, 33'h0);
    wclk_run(1'b0);
    $display("test wait clock done");
    for (p = 0; p < 2; p++) begin
      page <= p[0];
      apb(1'b1, A_CFG, {29'h0, p[0], 2'h0}, 33'h0);
      for (i = 0; i < 2; i++) begin
        tmp = $random(seed);
        adr[i] = {~i[0], tmp[14:0]};
        dat[i] = tmp[23:16];
        bus(1'b1, adr[i], dat[i], 8'h0, 1'b1);
      end
      for (r = 0; r < 4; r++) begin
        apb(1'b1, A_CFG, {29'h0, p[0], r[1:0]}, 33'h0);
        if (r == 3) bus(1'b1, adr[0], ~dat[0], 8'h0, 1'b0);
        for (i = 0; i < 2; i++) begin
          inr = (r == 0) || (r == 1 && adr[i][15]) || (r == 2 && !adr[i][15]);
          bus(1'b0, adr[i], dat[i], inr ? dat[i] : 8'h0, inr);
        end
      end
    end
    apb(1'b0, A_CFG, 32'h0, 33'h7);
    $display("test strobe range and ports done");
    apb(1'b1, A_CFG, 32'h0, 33'h0);
    page <= 1'b0;
    stall_len <= 4'h8;
    bus(1'b1, 16'h1234, 8'h5A, 8'h0, 1'b1);
    check(33'(lat), 33'(NOM));
    apb(1'b1, A_STALL, 32'h1, 33'h0);
    bus(1'b1, 16'h1234, 8'hA5, 8'h0, 1'b1);
    check({32'h0, lat > NOM}, 33'h1);
    bus(1'b0, 16'h1234, 8'h00, 8'hA5, 1'b1);
    check({32'h0, lat > NOM}, 33'h1);
    // status while held by the ready stall pin
    stall_len <= 4'hF;
    req_valid <= 1'b1;
    req <= {1'b0, 16'h1234, 8'h00};
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b0, A_STAT, 32'h0, 33'h3);
    exp_q.push_back(33'h0A5);
    lat = 0;
    while (req_done !== 1'b1 && lat < 60) begin
      @(posedge clock);
      lat++;
    end
    if (req_done !== 1'b1) begin
      errors++;
      stop_test();
    end
    @(posedge clock);
    $display("test ready stall done");
    stop_test();
  end
endmodule
